/* File: hs_pwm_bank.sv */
/*
 * Banked PWM setup register, four high-side PWM generators and the
 * system scratch register, behind a classic Wishbone slave.
 * Assumes SOFT_RESET, RESTART and NORMAL_MODE come from on-chip logic
 * on CORE_CLK, and that CORE_CLK is the on-chip oscillator.
 */
`timescale 1ns/1ps

module hs_pwm_bank #(
   parameter int STEP_SLOW = hs_pwm_pkg::STEP_SLOW_CYC, // Cycles per step, slow rate
   parameter int STEP_FAST = hs_pwm_pkg::STEP_FAST_CYC  // Cycles per step, fast rate
) (
   // Clock and reset
   input  wire logic                          CORE_CLK,
   input  wire logic                          RST,
   // Device mode and reset events
   input  wire logic                          SOFT_RESET,
   input  wire logic                          RESTART,
   input  wire logic                          NORMAL_MODE,
   // Wishbone slave
   input  wire logic                          WB_CYC_I,
   input  wire logic                          WB_STB_I,
   input  wire logic                          WB_WE_I,
   input  wire logic [hs_pwm_pkg::ADDR_W-1:0] WB_ADR_I,
   input  wire logic [3:0]                    WB_SEL_I,
   input  wire logic [hs_pwm_pkg::DATA_W-1:0] WB_DAT_I,
   output      logic [hs_pwm_pkg::DATA_W-1:0] WB_DAT_O,
   output      logic                          WB_ACK_O,
   // High-side switch drives
   output      logic [hs_pwm_pkg::NUM_GEN-1:0] HIGH_SIDE_SWITCH_PWM
);

   // ==========================================================
   // Declarations
   // ==========================================================
   localparam int RW = hs_pwm_pkg::REG_W;
   localparam int DW = hs_pwm_pkg::DATA_W;
   localparam int NG = hs_pwm_pkg::NUM_GEN;

   logic          ack, next_ack;          // Registered acknowledge
   logic [DW-1:0] rdat, next_rdat;        // Registered read data
   logic [RW-1:0] setup, next_setup;      // PWM setup register
   logic          req;                    // Request present
   logic          wr_take;                // Write takes effect now
   logic [RW-1:0] lane_mask;              // Byte lanes of the low half
   logic [RW-1:0] merged;                 // Setup after a write
   logic [RW-1:0] base;                   // Setup after restart
   logic [NG-1:0] gen_load;               // Per generator load
   logic [NG-1:0] gen_out;                // Per generator drive
   logic          hit_setup;              // Address is setup
   logic          hit_scratch;            // Address is scratch
   logic          hit_status;             // Address is status
   logic [RW-1:0] setup_view;             // Setup as read back
   logic [RW-1:0] status_view;            // Status as read back

   pwm_cfg_if     gen_if [NG] ();         // Generator carriers
   scratch_if     scr_if ();              // Scratch carrier

   // ==========================================================
   // Address decode and request
   // ==========================================================
   assign req         = WB_CYC_I & WB_STB_I;
   assign hit_setup   = (WB_ADR_I == hs_pwm_pkg::PWM_SETUP_ADDR);
   assign hit_scratch = (WB_ADR_I == hs_pwm_pkg::SCRATCH_ADDR);
   assign hit_status  = (WB_ADR_I == hs_pwm_pkg::GEN_STATUS_ADDR);
   // Write lands on the edge where the master sees ack
   assign wr_take     = req & WB_WE_I & ack;
   // Only lanes 0 and 1 carry register bits
   assign lane_mask   = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

   // ==========================================================
   // Bus handshake next state
   // ==========================================================
   always_comb begin
      // Ack one cycle after the request, dropped the cycle after
      next_ack  = req & ~ack;
      next_rdat = rdat;
      if (req & ~ack) begin
         if (WB_WE_I) begin
            // Writes return zero data
            next_rdat = hs_pwm_pkg::UNMAPPED_RD;
         end else if (hit_setup) begin
            next_rdat = {{(DW - RW){1'b0}}, setup_view};
         end else if (hit_scratch) begin
            next_rdat = NORMAL_MODE ? {{(DW - RW){1'b0}}, scr_if.rdata}
                                    : hs_pwm_pkg::UNMAPPED_RD;
         end else if (hit_status) begin
            next_rdat = {{(DW - RW){1'b0}}, status_view};
         end else begin
            // Unmapped address reads zero
            next_rdat = hs_pwm_pkg::UNMAPPED_RD;
         end
      end
   end

   // ==========================================================
   // Bus handshake registers
   // ==========================================================
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ack  <= 1'b0;
         rdat <= '0;
      end else begin
         ack  <= next_ack;
         rdat <= next_rdat;
      end
   end

   assign WB_ACK_O = ack;
   assign WB_DAT_O = rdat;

   // ==========================================================
   // Read views
   // ==========================================================
   // Reserved bits forced to zero
   assign setup_view = setup & hs_pwm_pkg::SETUP_RW_MASK;

   // Live switch drives and the mode bit
   always_comb begin
      status_view = '0;
      status_view[NG-1:0] = gen_out;
      status_view[hs_pwm_pkg::STAT_MODE_BIT] = NORMAL_MODE;
   end

   // ==========================================================
   // PWM setup register next state
   // ==========================================================
   always_comb begin
      next_setup = setup;
      gen_load   = '0;
      base   = RESTART ? (setup & hs_pwm_pkg::RESTART_KEEP_MASK) : setup;
      merged = ((base & ~lane_mask) | (WB_DAT_I[RW-1:0] & lane_mask))
             & hs_pwm_pkg::SETUP_RW_MASK;
      if (wr_take & hit_setup) begin
         next_setup = merged;
         // Top selector bit means no generator
         if (!merged[hs_pwm_pkg::SEL_TOP]) begin
            gen_load[merged[1:0]] = 1'b1;
         end
      end else begin
         next_setup = base;
      end
      if (SOFT_RESET) begin
         next_setup = hs_pwm_pkg::PWM_SETUP_RST;
         gen_load   = '0;
      end
   end

   // ==========================================================
   // PWM setup register
   // ==========================================================
   // Power-on clears the register
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         setup <= hs_pwm_pkg::PWM_SETUP_RST;
      end else begin
         setup <= next_setup;
      end
   end

   // ==========================================================
   // Generators
   // ==========================================================
   // One generator per switch
   for (genvar g = 0; g < NG; g++) begin : gen_bank
      // Rate bit selects 100 or 200 Hz
      assign gen_if[g].rate = merged[hs_pwm_pkg::RATE_BIT];
      assign gen_if[g].duty = merged[hs_pwm_pkg::DUTY_HI:hs_pwm_pkg::DUTY_LO];
      assign gen_if[g].load = gen_load[g];
      assign gen_out[g]     = gen_if[g].pwm_out;

      pwm_generator #(
         .STEP_SLOW (STEP_SLOW),
         .STEP_FAST (STEP_FAST)
      ) u_gen (
         .clk      (CORE_CLK),
         .rst      (RST),
         .soft_clr (SOFT_RESET),
         .cfg      (gen_if[g])
      );
   end

   // Registered drives go straight to the switch pins
   assign HIGH_SIDE_SWITCH_PWM = gen_out;

   // ==========================================================
   // Scratch register
   // ==========================================================
   // Writes honoured in normal mode only
   assign scr_if.wr    = wr_take & hit_scratch & NORMAL_MODE;
   assign scr_if.wmask = lane_mask;
   assign scr_if.wdata = WB_DAT_I[RW-1:0];

   // Restart never reaches the scratch store
   // Only the bus slave, SOFT_RESET and RST touch it
   scratch_store u_scratch (
      .clk      (CORE_CLK),
      .rst      (RST),
      .soft_clr (SOFT_RESET),
      .acc      (scr_if)
   );

endmodule : hs_pwm_bank

/* File: hs_pwm_pkg.sv */
/*
 * Shared constants for the high-side PWM bank and the system scratch
 * register: register indices, field positions, reset values, timing.
 * Assumes a single core clock that is the on-chip oscillator.
 */
package hs_pwm_pkg;

   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int CLK_HZ        = 10_000_000; // Core oscillator rate
   localparam int RATE_SLOW_HZ  = 100;        // Rate select low
   localparam int RATE_FAST_HZ  = 200;        // Rate select high
   localparam int DUTY_STEPS    = 1024;       // Steps per period
   // Cycles per duty step, rounded down, never below one
   localparam int STEP_SLOW_CYC = (CLK_HZ / (RATE_SLOW_HZ * DUTY_STEPS) < 1) ? 1
                                : CLK_HZ / (RATE_SLOW_HZ * DUTY_STEPS);
   localparam int STEP_FAST_CYC = (CLK_HZ / (RATE_FAST_HZ * DUTY_STEPS) < 1) ? 1
                                : CLK_HZ / (RATE_FAST_HZ * DUTY_STEPS);
   localparam int PRESC_W       = 16;         // Step prescaler width

   // ==========================================================
   // Bus and register map
   // ==========================================================
   localparam int ADDR_W = 8;                 // Byte address width
   localparam int DATA_W = 32;                // Wishbone data width
   localparam int REG_W  = 16;                // Register width
   localparam int NUM_GEN = 4;                // Generator count
   localparam logic [ADDR_W-1:0] PWM_SETUP_IDX  = 8'h0A;
   localparam logic [ADDR_W-1:0] SCRATCH_IDX    = 8'h0B;
   localparam logic [ADDR_W-1:0] GEN_STATUS_IDX = 8'h0C;
   localparam logic [ADDR_W-1:0] PWM_SETUP_ADDR  = {PWM_SETUP_IDX[5:0], 2'b00};
   localparam logic [ADDR_W-1:0] SCRATCH_ADDR    = {SCRATCH_IDX[5:0], 2'b00};
   localparam logic [ADDR_W-1:0] GEN_STATUS_ADDR = {GEN_STATUS_IDX[5:0], 2'b00};

   // ==========================================================
   // Field layout of the PWM setup register
   // ==========================================================
   localparam int RATE_BIT = 14;
   localparam int DUTY_HI  = 13;
   localparam int DUTY_LO  = 4;
   localparam int SEL_HI   = 2;
   localparam int SEL_LO   = 0;
   localparam int SEL_TOP  = 2;                // Set means no generator
   localparam int DUTY_W   = DUTY_HI - DUTY_LO + 1;
   localparam int STAT_MODE_BIT = 4;           // Status: normal mode
   localparam logic [REG_W-1:0]  SETUP_RW_MASK     = 16'h7FF7;
   localparam logic [REG_W-1:0]  RESTART_KEEP_MASK = 16'h7FF0;
   localparam logic [DUTY_W-1:0] DUTY_OFF = 10'h000;
   localparam logic [DUTY_W-1:0] DUTY_ON  = 10'h3FF;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [REG_W-1:0]  PWM_SETUP_RST = 16'h0000;
   localparam logic [REG_W-1:0]  SCRATCH_RST   = 16'h0000;
   localparam logic [DATA_W-1:0] UNMAPPED_RD   = 32'h0000_0000;

endpackage : hs_pwm_pkg

/* File: hs_pwm_ifs.sv */
/*
 * Carriers between the bank top and its generator and scratch modules.
 * Assumes the package hs_pwm_pkg is compiled first.
 */
`timescale 1ns/1ps

// ==========================================================
// One generator's configuration and output
// ==========================================================
interface pwm_cfg_if;
   logic                          load;    // Store rate and duty
   logic                          rate;    // Rate select
   logic [hs_pwm_pkg::DUTY_W-1:0] duty;    // Duty steps
   logic                          pwm_out; // Switch drive
   modport bank (output load, rate, duty, input pwm_out);
   modport gen  (input load, rate, duty, output pwm_out);
endinterface : pwm_cfg_if

// ==========================================================
// Scratch storage access from the bus slave
// ==========================================================
interface scratch_if;
   logic                         wr;      // Write strobe
   logic [hs_pwm_pkg::REG_W-1:0] wmask;   // Byte lane mask
   logic [hs_pwm_pkg::REG_W-1:0] wdata;   // Write data
   logic [hs_pwm_pkg::REG_W-1:0] rdata;   // Stored value
   modport bank  (output wr, wmask, wdata, input rdata);
   modport store (input wr, wmask, wdata, output rdata);
endinterface : scratch_if

/* File: pwm_generator.sv */
/*
 * One PWM generator: prescaled step counter, 1024 steps per period,
 * registered output. Assumes the core clock is the on-chip oscillator.
 */
`timescale 1ns/1ps

module pwm_generator #(
   parameter int STEP_SLOW = hs_pwm_pkg::STEP_SLOW_CYC, // Cycles per step, slow
   parameter int STEP_FAST = hs_pwm_pkg::STEP_FAST_CYC  // Cycles per step, fast
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic soft_clr,
   // Configuration and output
   pwm_cfg_if.gen    cfg
);
   localparam int PW = hs_pwm_pkg::PRESC_W;
   localparam int DW = hs_pwm_pkg::DUTY_W;
   localparam logic [PW-1:0] LIM_SLOW = PW'(STEP_SLOW - 1);
   localparam logic [PW-1:0] LIM_FAST = PW'(STEP_FAST - 1);

   logic          rate, next_rate;   // Stored rate select
   logic [DW-1:0] duty, next_duty;   // Stored duty
   logic [PW-1:0] presc, next_presc; // Step prescaler
   logic [DW-1:0] step, next_step;   // Position in period
   logic          out, next_out;     // Registered drive

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      next_rate  = rate;
      next_duty  = duty;
      next_presc = presc + PW'(1);
      next_step  = step;
      if (presc >= (rate ? LIM_FAST : LIM_SLOW)) begin
         next_presc = '0;
         next_step  = step + DW'(1);
      end
      if (cfg.load) begin
         next_rate = cfg.rate;
         next_duty = cfg.duty;
      end
      if (soft_clr) begin
         next_rate  = 1'b0;
         next_duty  = hs_pwm_pkg::DUTY_OFF;
         next_presc = '0;
         next_step  = '0;
      end
      // Off, on, or fraction of 1024
      if (duty == hs_pwm_pkg::DUTY_OFF) begin
         next_out = 1'b0;
      end else if (duty == hs_pwm_pkg::DUTY_ON) begin
         next_out = 1'b1;
      end else begin
         next_out = (step < duty);
      end
   end

   // ==========================================================
   // Registers
   // ==========================================================
   // New settings apply mid period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rate  <= 1'b0;
         duty  <= '0;
         presc <= '0;
         step  <= '0;
         out   <= 1'b0;
      end else begin
         rate  <= next_rate;
         duty  <= next_duty;
         presc <= next_presc;
         step  <= next_step;
         out   <= next_out;
      end
   end

   assign cfg.pwm_out = out;

endmodule : pwm_generator

/* File: scratch_store.sv */
/*
 * Sixteen-bit scratch storage with byte lane writes. Only the bus
 * slave reads or writes it; other logic only clears it, on soft_clr or rst.
 */
`timescale 1ns/1ps

module scratch_store (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic soft_clr,
   // Bus side access
   scratch_if.store  acc
);
   logic [hs_pwm_pkg::REG_W-1:0] value, next_value; // Stored word

   // ==========================================================
   // Next value
   // ==========================================================
   always_comb begin
      next_value = value;
      if (acc.wr) begin
         next_value = (value & ~acc.wmask) | (acc.wdata & acc.wmask);
      end
      if (soft_clr) begin
         next_value = hs_pwm_pkg::SCRATCH_RST;
      end
   end

   // ==========================================================
   // Register
   // ==========================================================
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         value <= hs_pwm_pkg::SCRATCH_RST;
      end else begin
         value <= next_value;
      end
   end

   assign acc.rdata = value;

endmodule : scratch_store

/* File: hs_pwm_bank_sva.sv */
/* Checker for hs_pwm_bank: bus answer timing and register read rules.
   Assumes one core clock and RST as its asynchronous reset. */
`timescale 1ns/1ps
module hs_pwm_bank_chk #(
   parameter int STEP_SLOW = 2, // Cycles per step, slow
   parameter int STEP_FAST = 1  // Cycles per step, fast
) (
   // Clock and reset
   input wire logic        CORE_CLK,
   input wire logic        RST,
   // Mode and events
   input wire logic        SOFT_RESET,
   input wire logic        RESTART,
   input wire logic        NORMAL_MODE,
   // Wishbone
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [3:0]  WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   // Switch drives
   input wire logic [3:0]  HIGH_SIDE_SWITCH_PWM
);
   // ==========================================
   // Helpers
   // ==========================================
   logic req;    // Request present
   logic rd_ack; // Read answered
   logic mapped; // Address decodes
   assign req    = WB_CYC_I & WB_STB_I;
   assign rd_ack = WB_ACK_O & ~WB_WE_I;
   assign mapped = (WB_ADR_I == hs_pwm_pkg::PWM_SETUP_ADDR) | (WB_ADR_I == hs_pwm_pkg::SCRATCH_ADDR)
                 | (WB_ADR_I == hs_pwm_pkg::GEN_STATUS_ADDR);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   // ==========================================
   // Assertions
   // ==========================================
   a_ack_next_cycle: assert property (req && !WB_ACK_O |=> WB_ACK_O)
      else $error("Request not answered in the next cycle");
   a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("Acknowledge held longer than one cycle");
   a_ack_needs_req: assert property (!req |=> !WB_ACK_O)
      else $error("Acknowledge without a request");
   a_reserved_read_zero: assert property (
      rd_ack && WB_ADR_I == hs_pwm_pkg::PWM_SETUP_ADDR |-> !WB_DAT_O[15] && !WB_DAT_O[3] && WB_DAT_O[31:16] == 16'h0000)
      else $error("Reserved setup bits read nonzero");
   a_unmapped_read_zero: assert property (rd_ack && !mapped |-> WB_DAT_O == 32'h0000_0000)
      else $error("Unmapped read returned data");
   a_scratch_mode_gate: assert property (
      rd_ack && WB_ADR_I == hs_pwm_pkg::SCRATCH_ADDR && !$past(NORMAL_MODE) |-> WB_DAT_O == 32'h0000_0000)
      else $error("Scratch readable outside normal mode");
   a_reset_quiet_out: assert property ($fell(RST) |-> !WB_ACK_O && HIGH_SIDE_SWITCH_PWM == 4'h0)
      else $error("Outputs active right after reset");
   a_soft_clears_pwm: assert property (SOFT_RESET |=> ##1 HIGH_SIDE_SWITCH_PWM == 4'h0)
      else $error("Switch drives not cleared by soft reset");
   // Main scenarios reached
   c_write_done: cover property (WB_ACK_O && WB_WE_I);
   c_soft_reset: cover property (SOFT_RESET);
   c_restart: cover property (RESTART);
endmodule : hs_pwm_bank_chk

bind hs_pwm_bank hs_pwm_bank_chk #(.STEP_SLOW(STEP_SLOW), .STEP_FAST(STEP_FAST)) chk_u (
   .CORE_CLK(CORE_CLK), .RST(RST), .SOFT_RESET(SOFT_RESET), .RESTART(RESTART),
   .NORMAL_MODE(NORMAL_MODE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
   .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .HIGH_SIDE_SWITCH_PWM(HIGH_SIDE_SWITCH_PWM));

/* File: hs_pwm_bank_bench.sv */
/* Self-checking bench for hs_pwm_bank, driven over Wishbone.
   Assumes shortened step counts so one period is 1024 or 2048 cycles. */
`timescale 1ns/1ps
module hs_pwm_bank_bench;
   localparam int step_slow = 2; // Short slow step
   localparam int step_fast = 1; // Short fast step
   // ==========================================
   // Stimulus and observed signals
   // ==========================================
   logic        clk = 1'b0;      // Core clock
   logic        rst = 1'b1;      // Power-on reset
   logic        soft_reset = 1'b0;
   logic        restart = 1'b0;
   logic        normal_mode = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;            // Read data
   logic        ack;             // Answer
   logic [3:0]  pwm;             // Switch drives
   logic [31:0] q;               // Last read value
   int          n_fail = 0;
   int          n_checks = 0;
   // Clock of 100 ns
   always #50 clk = ~clk;
   hs_pwm_bank #(.STEP_SLOW(step_slow), .STEP_FAST(step_fast)) dut_u (
      .CORE_CLK(clk), .RST(rst), .SOFT_RESET(soft_reset), .RESTART(restart),
      .NORMAL_MODE(normal_mode), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .HIGH_SIDE_SWITCH_PWM(pwm));
   // ==========================================
   // Shared tasks
   // ==========================================
   task tally_and_finish;
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One classic cycle, held until acknowledge
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      // Sample ack at each rising edge; take data at that same edge
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1) begin
         n_fail++;
         $display("Error at %0t: no acknowledge", $time);
         tally_and_finish();
      end
   endtask : wb
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000, 4'h0);
      chk(q, exp);
   endtask : rd_chk
   task settle;
      repeat (6) @(negedge clk);
   endtask : settle
   // ==========================================
   // Scenarios
   // ==========================================
   task t_reset_vals;
      rd_chk(hs_pwm_pkg::PWM_SETUP_ADDR, 32'h0000_0000);
      rd_chk(hs_pwm_pkg::SCRATCH_ADDR, 32'h0000_0000);
      wb(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
      rd_chk(8'h40, 32'h0000_0000);
      chk({28'h0, pwm}, 32'h0000_0000);
      $display("Test reset values done");
   endtask : t_reset_vals
   task t_fields;
      wb(1'b1, hs_pwm_pkg::PWM_SETUP_ADDR, 32'hFFFF_FFFC, 4'h3);
      rd_chk(hs_pwm_pkg::PWM_SETUP_ADDR, 32'h0000_7FF4);
      settle();
      chk({28'h0, pwm}, 32'h0000_0000);
      for (int g = 0; g < 4; g++) begin
         wb(1'b1, hs_pwm_pkg::PWM_SETUP_ADDR, {18'h0, 10'h3FF, 1'b0, g[2:0]}, 4'h3);
         settle();
         chk({28'h0, pwm}, (32'h1 << (g + 1)) - 32'h1);
      end
      wb(1'b1, hs_pwm_pkg::PWM_SETUP_ADDR, 32'h0000_0002, 4'h3);
      settle();
      chk({28'h0, pwm}, 32'h0000_000B);
      // Status view: live drives in bits 3:0, normal mode in bit 4
      rd_chk(hs_pwm_pkg::GEN_STATUS_ADDR, 32'h0000_001B);
      $display("Test fields and selector done");
   endtask : t_fields
   task t_duty_frac;
      int per;
      int hi;
      int rises;
      logic prev;
      for (int r = 0; r < 2; r++) begin
         per = 1024 * ((r == 1) ? step_fast : step_slow);
         wb(1'b1, hs_pwm_pkg::PWM_SETUP_ADDR, {17'h0, r[0], 10'h100, 4'h1}, 4'h3);
         repeat (2 * per) @(negedge clk);
         hi = 0;
         rises = 0;
         prev = pwm[1];
         repeat (4096) begin
            @(negedge clk);
            if (pwm[1] === 1'b1)
               hi++;
            if (pwm[1] === 1'b1 && prev === 1'b0)
               rises++;
            prev = pwm[1];
         end
         chk(hi, 32'd1024);
         chk(rises, 4096 / per);
      end
      $display("Test duty fraction and rate done");
   endtask : t_duty_frac
   task t_scratch;
      wb(1'b1, hs_pwm_pkg::SCRATCH_ADDR, 32'h0000_A5C3, 4'h3);
      rd_chk(hs_pwm_pkg::SCRATCH_ADDR, 32'h0000_A5C3);
      wb(1'b1, hs_pwm_pkg::SCRATCH_ADDR, 32'h0000_1234, 4'h2);
      rd_chk(hs_pwm_pkg::SCRATCH_ADDR, 32'h0000_12C3);
      @(posedge clk);
      normal_mode <= 1'b0;
      wb(1'b1, hs_pwm_pkg::SCRATCH_ADDR, 32'h0000_FFFF, 4'h3);
      rd_chk(hs_pwm_pkg::SCRATCH_ADDR, 32'h0000_0000);
      normal_mode <= 1'b1;
      rd_chk(hs_pwm_pkg::SCRATCH_ADDR, 32'h0000_12C3);
      $display("Test scratch access done");
   endtask : t_scratch
   task t_restart;
      wb(1'b1, hs_pwm_pkg::PWM_SETUP_ADDR, 32'h0000_4AB6, 4'h3);
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      rd_chk(hs_pwm_pkg::PWM_SETUP_ADDR, 32'h0000_4AB0);
      rd_chk(hs_pwm_pkg::SCRATCH_ADDR, 32'h0000_12C3);
      $display("Test restart done");
   endtask : t_restart
   task t_soft;
      @(posedge clk);
      soft_reset <= 1'b1;
      @(posedge clk);
      soft_reset <= 1'b0;
      rd_chk(hs_pwm_pkg::SCRATCH_ADDR, 32'h0000_0000);
      rd_chk(hs_pwm_pkg::PWM_SETUP_ADDR, 32'h0000_0000);
      chk({28'h0, pwm}, 32'h0000_0000);
      $display("Test soft reset done");
   endtask : t_soft
   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset_vals();
      t_fields();
      t_duty_frac();
      t_scratch();
      t_restart();
      t_soft();
      tally_and_finish();
   end
endmodule : hs_pwm_bank_bench
